// >>> hw/arf_cfg.svh
// register offsets, field positions and reset values of the alarm relay block
`ifndef ARF_CFG_SVH
`define ARF_CFG_SVH

`define ARF_RACKS 6
`define ARF_LAMPS 3
`define ARF_LEDS 3
`define ARF_STATE_W 28
`define ARF_IRQ_W 11

`define ARF_OFS_ALARM_REQ 8'h00
`define ARF_OFS_GROUP_REQ 8'h04
`define ARF_OFS_FAN_RELAY 8'h08
`define ARF_OFS_FAN_ALARM 8'h0C
`define ARF_OFS_LED_CTRL 8'h10
`define ARF_OFS_RELAY_STATE 8'h14
`define ARF_OFS_IRQ_STATUS 8'h18
`define ARF_OFS_IRQ_ENABLE 8'h1C
`define ARF_OFS_IRQ_CLEAR 8'h20
`define ARF_OFS_LAMP_FAIL 8'h24
`define ARF_OFS_SANITY 8'h28

`define ARF_REQ_CRIT_LSB 0
`define ARF_REQ_MAJ_LSB 6
`define ARF_REQ_MIN_LSB 12
`define ARF_REQ_AUD_BIT 18
`define ARF_REQ_BUZ_BIT 19
`define ARF_REQ_FWD_BIT 20
`define ARF_REQ_W 21

`define ARF_GRP_REMOTE_LSB 0
`define ARF_GRP_LOCAL_LSB 3
`define ARF_GRP_ROW_LSB 6
`define ARF_GRP_W 9

`define ARF_ST_AUD_BIT 18
`define ARF_ST_REMOTE_LSB 19
`define ARF_ST_LOCAL_LSB 22
`define ARF_ST_ROW_LSB 25

`define ARF_IRQ_LAMP_LSB 0
`define ARF_IRQ_FAN_LSB 3
`define ARF_IRQ_INSANE_BIT 9
`define ARF_IRQ_POWER_BIT 10

`define ARF_RST_REQ 21'h000000
`define ARF_RST_GRP 9'h000
`define ARF_RST_FAN 6'h00
`define ARF_RST_LED 6'h00
`define ARF_RST_IRQ 11'h000

`endif

// >>> hw/arf_fan_ctrl.sv
// per-frame fan relay drive and fan alarm sensing
`timescale 1ns/1ns
`default_nettype none

module arf_fan_ctrl (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [5:0] fan_stop,
    input wire logic [5:0] fan_alarm_in,
    output logic [5:0] fan_ctl_out,
    output logic [5:0] fan_ctl_oe_n,
    output logic [5:0] fan_alarm,
    output logic [5:0] fan_alarm_rise
);

    genvar f;
    generate
        for (f = 0; f < 6; f = f + 1) begin : g_frame
            // open circuit runs the fans, so reset leaves them running
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    fan_ctl_out[f] <= 1'b0;
                    fan_ctl_oe_n[f] <= 1'b1;
                end else begin
                    fan_ctl_out[f] <= 1'b0;
                    fan_ctl_oe_n[f] <= ~fan_stop[f];
                end
            end

            // each frame's optocoupler latched on its own
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    fan_alarm[f] <= 1'b0;
                    fan_alarm_rise[f] <= 1'b0;
                end else begin
                    fan_alarm[f] <= fan_alarm_in[f];
                    fan_alarm_rise[f] <= fan_alarm_in[f] & ~fan_alarm[f];
                end
            end
        end
    endgenerate

endmodule : arf_fan_ctrl

`default_nettype wire

// >>> hw/arf_lamp_check.sv
// lamp failure sensing on the remote center alarm circuits
`timescale 1ns/1ns
`default_nettype none

module arf_lamp_check (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [2:0] alarm_on,
    input wire logic [2:0] lamp_current,
    output logic [2:0] lamp_fail,
    output logic [2:0] lamp_fail_rise
);

    genvar i;
    generate
        for (i = 0; i < 3; i = i + 1) begin : g_lamp
            // no current while driven means a dead or missing bulb
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    lamp_fail[i] <= 1'b0;
                    lamp_fail_rise[i] <= 1'b0;
                end else begin
                    lamp_fail[i] <= alarm_on[i] & ~lamp_current[i];
                    lamp_fail_rise[i] <= alarm_on[i] & ~lamp_current[i]
                        & ~lamp_fail[i];
                end
            end
        end
    endgenerate

endmodule : arf_lamp_check

`default_nettype wire

// >>> hw/arf_pkg.sv
// types shared by the alarm relay and fan control block
package arf_pkg;

    // software-selected state of one bicolor system alarm led
    typedef enum logic [1:0] {
        arf_led_off = 2'b00,
        arf_led_clear = 2'b01,
        arf_led_alarm = 2'b10,
        arf_led_other = 2'b11
    } arf_led_mode_t;

endpackage : arf_pkg

// >>> hw/arf_top.sv
// alarm relay, lamp check, fan and led control with apb register access
`timescale 1ns/1ns
`default_nettype none
`include "arf_cfg.svh"

// Overview of operation
// - major and minor relays need a primary request and one sane card
// - critical on request, both cards insane, or lost power
// - critical relays energise to clear, so unpowered means alarming
// - remote center outputs pass only while forwarding is enabled
// - active remote alarm with no lamp current flags a lamp failure
// - relay state readable on both alarm buses whichever card is primary
// - critical, major, minor per rack for six racks, plus audible alarm
// - alarms grouped as rack, remote center, local center, row end
// - one fan relay per frame, each set on its own
// - legacy fan output left open to run, driven to stop
// - one fan alarm input per frame, each readable alone
// - five bicolor leds; alarm leds have four software states
// - processor leds green for primary card, off for standby
// - buzzer on both insane, or sanity plus primary request
// - critical, major red, minor amber in alarm mode, all green in clear mode
module arf_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic pmaster_b,
    input wire logic primary_b,
    input wire logic sane_a,
    input wire logic sane_b,
    input wire logic power_ok,
    input wire logic [2:0] lamp_current,
    input wire logic [5:0] fan_alarm_in,
    output logic [5:0] rack_critical_hold,
    output logic [5:0] rack_major_relay,
    output logic [5:0] rack_minor_relay,
    output logic audible_relay,
    output logic [2:0] remote_center_alarm,
    output logic [2:0] local_center_alarm,
    output logic [2:0] row_end_alarm,
    output logic [5:0] fan_ctl_out,
    output logic [5:0] fan_ctl_oe_n,
    output logic [2:0] led_red,
    output logic [2:0] led_green,
    output logic processor_a_led,
    output logic processor_b_led,
    output logic buzzer,
    output logic [27:0] relay_state_bus_a,
    output logic [27:0] relay_state_bus_b,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////
    // software registers

    logic [20:0] alarm_req;
    logic [8:0] group_req;
    logic [5:0] fan_stop;
    logic [5:0] led_ctrl;
    logic [10:0] irq_status;
    logic [10:0] irq_enable;
    logic [27:0] relay_state;
    logic [2:0] lamp_fail;
    logic [2:0] lamp_fail_rise;
    logic [5:0] fan_alarm;
    logic [5:0] fan_alarm_rise;
    logic insane_q;
    logic power_lost_q;

    // apb phases
    logic setup_ph;
    logic access_wr;
    logic from_primary;
    logic wr_req;
    logic wr_grp;
    logic wr_fan;
    logic wr_led;
    logic wr_ien;
    logic wr_clr;
    assign setup_ph = psel & ~penable;
    assign access_wr = psel & penable & pwrite;
    // the standby card may look but not steer the relays
    assign from_primary = (pmaster_b == primary_b);
    assign wr_req = access_wr & from_primary
        & (paddr == `ARF_OFS_ALARM_REQ);
    assign wr_grp = access_wr & from_primary
        & (paddr == `ARF_OFS_GROUP_REQ);
    assign wr_fan = access_wr & from_primary
        & (paddr == `ARF_OFS_FAN_RELAY);
    assign wr_led = access_wr & from_primary
        & (paddr == `ARF_OFS_LED_CTRL);
    assign wr_ien = access_wr & (paddr == `ARF_OFS_IRQ_ENABLE);
    assign wr_clr = access_wr & (paddr == `ARF_OFS_IRQ_CLEAR);

    // requests from the primary card, kept until rewritten
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alarm_req <= `ARF_RST_REQ;
        end else if (wr_req) begin
            alarm_req <= pwdata[20:0];
        end
    end

    // remote, local and row end requests
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            group_req <= `ARF_RST_GRP;
        end else if (wr_grp) begin
            group_req <= pwdata[8:0];
        end
    end

    // fan stop bits, one per frame
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fan_stop <= `ARF_RST_FAN;
        end else if (wr_fan) begin
            fan_stop <= pwdata[5:0];
        end
    end

    // led modes, not tied to the relay logic
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            led_ctrl <= `ARF_RST_LED;
        end else if (wr_led) begin
            led_ctrl <= pwdata[5:0];
        end
    end

    // interrupt enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_enable <= `ARF_RST_IRQ;
        end else if (wr_ien) begin
            irq_enable <= pwdata[10:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // alarm relay logic

    logic sane_any;
    logic both_insane;
    logic crit_force;
    logic forward;
    logic [5:0] rack_crit;
    logic [5:0] rack_maj;
    logic [5:0] rack_min;
    logic aud;
    logic [2:0] remote;
    logic [2:0] local_grp;
    logic [2:0] row_end;
    logic [27:0] next_relay_state;

    assign sane_any = sane_a | sane_b;
    assign both_insane = ~sane_a & ~sane_b;
    assign crit_force = both_insane | ~power_ok;
    assign forward = alarm_req[`ARF_REQ_FWD_BIT];

    // relay decisions; bit 0 of each group is its critical alarm
    always_comb begin
        rack_crit = alarm_req[5:0] | {6{crit_force}};
        rack_maj = alarm_req[11:6] & {6{sane_any}};
        rack_min = alarm_req[17:12] & {6{sane_any}};
        aud = alarm_req[`ARF_REQ_AUD_BIT] & sane_any;
        remote = {group_req[2:1] & {2{sane_any}},
            group_req[0] | crit_force} & {3{forward}};
        local_grp = {group_req[5:4] & {2{sane_any}},
            group_req[3] | crit_force};
        row_end = {group_req[8:7] & {2{sane_any}},
            group_req[6] | crit_force};
        next_relay_state = {row_end, local_grp, remote, aud,
            rack_min, rack_maj, rack_crit};
    end

    // relay drive; reset leaves critical relays released, i.e. alarming
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            relay_state <= 28'h0000000;
            rack_critical_hold <= 6'h00;
            rack_major_relay <= 6'h00;
            rack_minor_relay <= 6'h00;
            audible_relay <= 1'b0;
            remote_center_alarm <= 3'h0;
            local_center_alarm <= 3'h0;
            row_end_alarm <= 3'h0;
        end else begin
            relay_state <= next_relay_state;
            rack_critical_hold <= ~rack_crit;
            rack_major_relay <= rack_maj;
            rack_minor_relay <= rack_min;
            audible_relay <= aud;
            remote_center_alarm <= {remote[2:1], ~remote[0]};
            local_center_alarm <= {local_grp[2:1], ~local_grp[0]};
            row_end_alarm <= {row_end[2:1], ~row_end[0]};
        end
    end

    // both alarm buses see the same relay picture
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            relay_state_bus_a <= 28'h0000000;
            relay_state_bus_b <= 28'h0000000;
        end else begin
            relay_state_bus_a <= next_relay_state;
            relay_state_bus_b <= next_relay_state;
        end
    end

    // buzzer and processor leds
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buzzer <= 1'b0;
            processor_a_led <= 1'b0;
            processor_b_led <= 1'b0;
        end else begin
            buzzer <= both_insane
                | (sane_any & alarm_req[`ARF_REQ_BUZ_BIT]);
            processor_a_led <= ~primary_b;
            processor_b_led <= primary_b;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // system alarm leds

    logic [2:0] next_red;
    logic [2:0] next_green;

    // led 0 critical, 1 major, 2 minor; minor alarms in amber
    always_comb begin
        next_red = 3'h0;
        next_green = 3'h0;
        for (int i = 0; i < 3; i++) begin
            case (arf_pkg::arf_led_mode_t'(led_ctrl[2*i +: 2]))
                arf_pkg::arf_led_clear: begin
                    next_green[i] = 1'b1;
                end
                arf_pkg::arf_led_alarm: begin
                    next_red[i] = 1'b1;
                    next_green[i] = (i == 2);
                end
                arf_pkg::arf_led_other: begin
                    next_red[i] = 1'b1;
                    next_green[i] = (i != 2);
                end
                default: begin
                    next_red[i] = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            led_red <= 3'h0;
            led_green <= 3'h0;
        end else begin
            led_red <= next_red;
            led_green <= next_green;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // lamp and fan helpers

    arf_lamp_check u_lamp (
        .pclk(pclk),
        .presetn(presetn),
        .alarm_on(relay_state[21:19]),
        .lamp_current(lamp_current),
        .lamp_fail(lamp_fail),
        .lamp_fail_rise(lamp_fail_rise)
    );

    arf_fan_ctrl u_fan (
        .pclk(pclk),
        .presetn(presetn),
        .fan_stop(fan_stop),
        .fan_alarm_in(fan_alarm_in),
        .fan_ctl_out(fan_ctl_out),
        .fan_ctl_oe_n(fan_ctl_oe_n),
        .fan_alarm(fan_alarm),
        .fan_alarm_rise(fan_alarm_rise)
    );

    ////////////////////////////////////////////////////////////////////////
    // interrupts

    logic [10:0] irq_events;
    assign irq_events = {~power_ok & ~power_lost_q, both_insane & ~insane_q,
        fan_alarm_rise, lamp_fail_rise};

    // edge memory for the sanity and power events
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            insane_q <= 1'b0;
            power_lost_q <= 1'b0;
        end else begin
            insane_q <= both_insane;
            power_lost_q <= ~power_ok;
        end
    end

    // sticky status; a new event outranks a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= `ARF_RST_IRQ;
        end else begin
            irq_status <= (irq_status & ~({11{wr_clr}} & pwdata[10:0]))
                | irq_events;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status & irq_enable);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // apb read path and error answer

    logic [31:0] next_rdata;
    logic next_err;

    // read data and error are settled in the setup cycle
    always_comb begin
        next_rdata = 32'h00000000;
        next_err = 1'b0;
        if (paddr == `ARF_OFS_ALARM_REQ) begin
            next_rdata = {11'h000, alarm_req};
            next_err = pwrite & ~from_primary;
        end else if (paddr == `ARF_OFS_GROUP_REQ) begin
            next_rdata = {23'h000000, group_req};
            next_err = pwrite & ~from_primary;
        end else if (paddr == `ARF_OFS_FAN_RELAY) begin
            next_rdata = {26'h0000000, fan_stop};
            next_err = pwrite & ~from_primary;
        end else if (paddr == `ARF_OFS_FAN_ALARM) begin
            next_rdata = {26'h0000000, fan_alarm};
            next_err = pwrite;
        end else if (paddr == `ARF_OFS_LED_CTRL) begin
            next_rdata = {26'h0000000, led_ctrl};
            next_err = pwrite & ~from_primary;
        end else if (paddr == `ARF_OFS_RELAY_STATE) begin
            next_rdata = {4'h0, relay_state};
            next_err = pwrite;
        end else if (paddr == `ARF_OFS_IRQ_STATUS) begin
            next_rdata = {21'h000000, irq_status};
            next_err = pwrite;
        end else if (paddr == `ARF_OFS_IRQ_ENABLE) begin
            next_rdata = {21'h000000, irq_enable};
        end else if (paddr == `ARF_OFS_IRQ_CLEAR) begin
            next_rdata = 32'h00000000;
        end else if (paddr == `ARF_OFS_LAMP_FAIL) begin
            next_rdata = {29'h00000000, lamp_fail};
            next_err = pwrite;
        end else if (paddr == `ARF_OFS_SANITY) begin
            next_rdata = {28'h0000000, power_ok, primary_b, sane_b, sane_a};
            next_err = pwrite;
        end else begin
            next_err = 1'b1;
        end
    end

    // zero wait state slave
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
            pready <= 1'b0;
        end else begin
            pready <= 1'b1;
            if (setup_ph) begin
                prdata <= pwrite ? 32'h00000000 : next_rdata;
                pslverr <= next_err;
            end
        end
    end

endmodule : arf_top

`default_nettype wire

// >>> tb/arf_panel_model.sv
// far side lamp panel: each unbroken lamp draws current while its alarm is lit
`timescale 1ns/1ns
`default_nettype none

module arf_panel_model (
    input wire logic [2:0] remote_center_alarm,
    input wire logic [2:0] broken,
    output logic [2:0] lamp_current
);
    // bit0 has hold polarity, so a low level means the lamp is lit
    assign lamp_current = {remote_center_alarm[2:1], ~remote_center_alarm[0]}
        & ~broken;
endmodule : arf_panel_model

`default_nettype wire

// >>> tb/arf_top_props.sv
// concurrent checks on the ports of the alarm relay block
`timescale 1ns/1ns
`default_nettype none

module arf_top_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic primary_b,
    input wire logic sane_a,
    input wire logic sane_b,
    input wire logic power_ok,
    input wire logic [5:0] rack_critical_hold,
    input wire logic [5:0] rack_major_relay,
    input wire logic [5:0] rack_minor_relay,
    input wire logic [5:0] fan_ctl_out,
    input wire logic processor_a_led,
    input wire logic processor_b_led,
    input wire logic buzzer,
    input wire logic [27:0] relay_state_bus_a,
    input wire logic [27:0] relay_state_bus_b
);
    // one clock domain, so clock and reset are given once
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    chk_major_gate: assert property (
        (!sane_a && !sane_b) |=> rack_major_relay == 6'h00
            && rack_minor_relay == 6'h00)
        else $error("major or minor relay set with no sane card");
    chk_crit_loss: assert property (
        (!sane_a && !sane_b) || !power_ok |=> rack_critical_hold == 6'h00)
        else $error("critical relay held with insane cards or no power");
    // the first edge after release still shows reset values, so skip it
    chk_state_match: assert property (
        $past(presetn) |-> relay_state_bus_a[17:0] == {rack_minor_relay,
            rack_major_relay, ~rack_critical_hold})
        else $error("relay state picture differs from relay outputs");
    chk_bus_same: assert property (
        relay_state_bus_a == relay_state_bus_b)
        else $error("relay state differs between the two buses");
    chk_buzz_insane: assert property (
        (!sane_a && !sane_b) |=> buzzer)
        else $error("buzzer silent with both cards insane");
    chk_proc_led: assert property (
        $past(presetn) |=> processor_b_led == $past(primary_b)
            && processor_a_led == !$past(primary_b))
        else $error("processor leds do not follow the primary card");
    chk_fan_drive: assert property (
        fan_ctl_out == 6'h00)
        else $error("fan control drives high");
    chk_pready_access: assert property (
        psel && penable |-> pready)
        else $error("access phase without ready");
endmodule : arf_top_props

`default_nettype wire

bind arf_top arf_top_props chk_u (.pclk, .presetn, .psel, .penable,
    .pready, .primary_b, .sane_a, .sane_b, .power_ok, .rack_critical_hold,
    .rack_major_relay, .rack_minor_relay, .fan_ctl_out, .processor_a_led,
    .processor_b_led, .buzzer, .relay_state_bus_a, .relay_state_bus_b);

// >>> tb/tb_top.sv
// self-checking bench for the alarm relay and fan control block
`timescale 1ns/1ns
`default_nettype none
`include "arf_cfg.svh"

module tb_top;
    localparam logic [31:0] all_bits = 32'hFFFFFFFF;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pmaster_b = 1'b0, primary_b = 1'b0;
    logic sane_a = 1'b1, sane_b = 1'b1, power_ok = 1'b1;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000, prdata, seed = 32'h00000027, r;
    logic [5:0] fan_alarm_in = 6'h00;
    logic [2:0] broken = 3'h0, lamp_current;
    logic pready, pslverr, audible_relay, buzzer, irq;
    logic processor_a_led, processor_b_led;
    logic [5:0] rack_critical_hold, rack_major_relay, rack_minor_relay;
    logic [5:0] fan_ctl_out, fan_ctl_oe_n;
    logic [2:0] remote_center_alarm, local_center_alarm, row_end_alarm;
    logic [2:0] led_red, led_green;
    logic [27:0] relay_state_bus_a, relay_state_bus_b;
    logic [64:0] q[$];
    logic [64:0] e;
    logic [20:0] req;
    int bad_count = 0, check_count = 0;

    always #50 pclk = ~pclk;

    arf_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .pmaster_b, .primary_b, .sane_a,
        .sane_b, .power_ok, .lamp_current, .fan_alarm_in, .rack_critical_hold,
        .rack_major_relay, .rack_minor_relay, .audible_relay,
        .remote_center_alarm, .local_center_alarm, .row_end_alarm,
        .fan_ctl_out, .fan_ctl_oe_n, .led_red, .led_green, .processor_a_led,
        .processor_b_led, .buzzer, .relay_state_bus_a, .relay_state_bus_b,
        .irq);
    arf_panel_model lamp_u (.remote_center_alarm, .broken, .lamp_current);

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    // s: some card sane; bad: both insane or power lost
    function automatic logic [31:0] st(input logic [20:0] a,
        input logic [8:0] g, input logic s, input logic bad);
        return {4'h0, g[8:3], g[2:0] & {3{a[20]}}, a[18:6] & {13{s}},
            a[5:0] | {6{bad}}};
    endfunction : st

    task automatic check(input string n, input logic [31:0] s,
        input logic [31:0] x);
        check_count++;
        if (s !== x) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", n, x, s);
        end
    endtask : check

    task automatic end_of_test();
        if (bad_count == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_of_test

    // releases the bus, so back-to-back transfers skip it
    task automatic tick(input int n);
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (n) @(posedge pclk);
    endtask : tick

    // d is write data or expected read data; m masks the compare
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, input logic [31:0] m, input logic err);
        q.push_back({err, m, d});
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
    endtask : apb

    ////////////////////////////////////////////////////////////////////////
    // scoreboard: oldest note against each completed access
    always @(posedge pclk) begin
        if (presetn && psel && penable && pready) begin
            e = q.pop_front();
            check("prdata", prdata & e[63:32], e[31:0] & e[63:32]);
            check("pslverr", {31'h0, pslverr}, {31'h0, e[64]});
        end
    end

    // hang guard, well above the length of the sequence
    initial begin
        repeat (3000) @(posedge pclk);
        bad_count++;
        end_of_test();
    end

    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        tick(2);
        check("crit_hold", rack_critical_hold, 6'h3F);
        apb(0, `ARF_OFS_ALARM_REQ, `ARF_RST_REQ, all_bits, 0);
        // random requests under random sanity
        for (int i = 0; i < 8; i++) begin
            r = xs();
            req = r[20:0];
            sane_a <= r[21];
            sane_b <= r[22];
            apb(1, `ARF_OFS_ALARM_REQ, {11'h0, req}, 0, 0);
            tick(2);
            apb(0, `ARF_OFS_RELAY_STATE, st(req, 9'h0, r[21] | r[22],
                !(r[21] | r[22])), 32'h0007FFFF, 0);
            check("buzzer", buzzer, (!r[21] && !r[22]) ||
                ((r[21] || r[22]) && req[19]));
            check("audible", audible_relay,
                req[18] && (r[21] || r[22]));
        end
        sane_a <= 1'b1;
        sane_b <= 1'b1;
        // standby card is refused, then switchover
        pmaster_b <= 1'b1;
        apb(1, `ARF_OFS_ALARM_REQ, 32'h001FFFFF, 0, 1);
        apb(0, `ARF_OFS_ALARM_REQ, {11'h0, req}, all_bits, 0);
        primary_b <= 1'b1;
        tick(2);
        check("proc_leds", {processor_a_led, processor_b_led}, 2'b01);
        apb(1, `ARF_OFS_ALARM_REQ, 0, 0, 0);
        apb(1, `ARF_OFS_GROUP_REQ, 32'h1FF, 0, 0);
        tick(2);
        apb(0, `ARF_OFS_RELAY_STATE, st(0, 9'h1FF, 1, 0), all_bits, 0);
        check("groups", {remote_center_alarm, local_center_alarm,
            row_end_alarm}, 9'b001_110_110);
        // broken middle lamp with forwarding on
        broken <= 3'b010;
        apb(1, `ARF_OFS_ALARM_REQ, 32'h00100000, 0, 0);
        tick(3);
        check("remote", remote_center_alarm, 3'b110);
        apb(0, `ARF_OFS_LAMP_FAIL, 32'h2, 32'h7, 0);
        apb(0, `ARF_OFS_IRQ_STATUS, 32'h2, 32'h7, 0);
        check("irq_masked", irq, 1'b0);
        apb(1, `ARF_OFS_IRQ_ENABLE, 32'h7, 0, 0);
        tick(2);
        check("irq_on", irq, 1'b1);
        apb(1, `ARF_OFS_IRQ_CLEAR, 32'h2, 0, 0);
        tick(2);
        check("irq_off", irq, 1'b0);
        apb(0, `ARF_OFS_IRQ_CLEAR, 0, all_bits, 0);
        apb(1, `ARF_OFS_RELAY_STATE, 0, 0, 1);
        apb(0, 8'h3C, 0, 0, 1);
        // fans: relays and alarm inputs per frame
        r = xs();
        apb(1, `ARF_OFS_FAN_RELAY, {26'h0, r[5:0]}, 0, 0);
        fan_alarm_in <= r[13:8];
        tick(2);
        check("fan_oe_n", fan_ctl_oe_n, {26'h0, ~r[5:0]});
        apb(0, `ARF_OFS_FAN_ALARM, {26'h0, r[13:8]}, 32'h3F, 0);
        // every led mode on all three alarm leds
        for (int m = 0; m < 4; m++) begin
            apb(1, `ARF_OFS_LED_CTRL, {26'h0, {3{m[1:0]}}}, 0, 0);
            tick(2);
            check("led_red", led_red, {3{m[1]}});
            check("led_green", led_green, {m[0] ^ m[1], m[0], m[0]});
        end
        // power loss, then both cards insane
        power_ok <= 1'b0;
        tick(2);
        check("crit_nopower", rack_critical_hold, 6'h00);
        power_ok <= 1'b1;
        sane_a <= 1'b0;
        sane_b <= 1'b0;
        tick(2);
        check("buzz_insane", buzzer, 1'b1);
        apb(0, `ARF_OFS_IRQ_STATUS, 32'h600, 32'h600, 0);
        tick(1);
        end_of_test();
    end
endmodule : tb_top

`default_nettype wire
